// ==== include/eep_pkg.sv ====
// Purpose: shared constants and types for the serial EEPROM host controller
// Assumes: 50 MHz system clock, two-wire bus run at or below 400 kHz
// Notes:   all timing counts derive from the times given in ns
package eep_pkg;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCL_PERIOD_NS = 2500;
   // quarter bit period, rounded up so the bus never runs too fast
   localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam int QTR_W = $clog2(QTR_CYC);
   localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
   localparam logic [QTR_W-1:0] QTR_ZERO = '0;

   // ***************************************************************
   // widths and fields
   // ***************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int LEN_W = 6;
   localparam int CS_W = 3;
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] DEV_TYPE = 4'hA;
   localparam logic [3:0] ADDR_HI_PAD = 4'h0;
   localparam logic RW_READ = 1'h1;
   localparam logic RW_WRITE = 1'h0;
   localparam logic [LEN_W-1:0] LEN_ONE = 6'h01;
   localparam logic [LEN_W-1:0] LEN_ZERO = 6'h00;

   // ***************************************************************
   // bit sequencing: four phases per bit, nine bits per byte
   // ***************************************************************
   localparam logic [1:0] PH_SET = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_FALL = 2'h3;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_ACK = 4'h8;

   typedef enum logic [2:0] {
      OP_WRITE = 3'h0,
      OP_READ_CUR = 3'h1,
      OP_READ_RAND = 3'h2,
      OP_POLL = 3'h3,
      OP_RECOVER = 3'h4
   } eep_op_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_START = 4'h1,
      ST_ADDR = 4'h3,
      ST_HI = 4'h2,
      ST_LO = 4'h6,
      ST_DATA = 4'h7,
      ST_RSTART = 4'h5,
      ST_RADDR = 4'h4,
      ST_RDATA = 4'hC,
      ST_STOP = 4'hD,
      ST_RECOV = 4'hF
   } eep_state_t;
endpackage

// ==== src/eep_fifo.sv ====
// Purpose: write-data FIFO with registered read data
// Assumes: single clock, valid/ready on both sides
// Notes:   holds DEPTH words in memory plus one in the output register
`timescale 1ns/100ps
module eep_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys, // system clock
   input wire logic arst_n, // async reset, active low
   input wire logic inValid, // write side valid
   output logic inReady, // write side ready
   input wire logic [WIDTH-1:0] inData, // write data
   output logic outValid, // read side valid
   input wire logic outReady, // read side ready
   output logic [WIDTH-1:0] outData // read data, registered
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_q, rdPtr_q;
   logic [PW:0] cnt_q;
   logic [WIDTH-1:0] outData_q;
   logic outValid_q;
   logic push, load;

   assign inReady = (cnt_q != CNT_FULL);
   assign push = inValid && inReady;
   assign load = (cnt_q != '0) && (!outValid_q || outReady);
   assign outValid = outValid_q;
   assign outData = outData_q;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (load) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(load);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         outData_q <= '0;
         outValid_q <= 1'b0;
      end else if (load) begin
         outData_q <= mem[rdPtr_q];
         outValid_q <= 1'b1;
      end else if (outReady) begin
         outValid_q <= 1'b0;
      end
   end
endmodule // eep_fifo

// ==== src/eep_host_ctrl.sv ====
// Purpose: two-wire bus master driving a serial EEPROM
// Assumes: single clk_sys domain; SCL made here by a divider; SDA open drain
// Notes:   write data pass through a 16-word FIFO; one command at a time
`timescale 1ns/100ps
module eep_host_ctrl (
   input wire logic clk_sys, // system clock, 50 MHz
   input wire logic arst_n, // async reset, active low
   input wire logic cmdValid, // command request
   output logic cmdReady, // command taken when high with cmdValid
   input wire eep_pkg::eep_op_t cmdOp, // operation
   input wire logic [eep_pkg::CS_W-1:0] cmdChip, // chip-select value of target
   input wire logic [eep_pkg::ADDR_W-1:0] cmdAddr, // byte address
   input wire logic [eep_pkg::LEN_W-1:0] cmdLen, // byte count, 0 taken as 1
   input wire logic wrValid, // write data valid
   output logic wrReady, // write FIFO has room
   input wire logic [eep_pkg::DATA_W-1:0] wrData, // write data
   output logic rdValid, // read byte pulse
   output logic [eep_pkg::DATA_W-1:0] rdData, // read byte
   output logic busy, // command in progress
   output logic done, // command finished pulse
   output logic nackSeen, // last command met a missing acknowledge
   output logic scl, // bus clock out
   input wire logic sdaIn, // data line level
   output logic sdaOut, // data line drive value
   output logic sdaOeN // data line enable, low drives
);
   import eep_pkg::*;

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   function automatic logic isTx(input eep_state_t s);
      return (s == ST_ADDR) || (s == ST_HI) || (s == ST_LO) || (s == ST_DATA) || (s == ST_RADDR);
   endfunction

   function automatic logic isBitSt(input eep_state_t s);
      return isTx(s) || (s == ST_RDATA) || (s == ST_RECOV);
   endfunction

   function automatic logic [DATA_W-1:0] devByte(input logic [CS_W-1:0] cs, input logic rw);
      return {DEV_TYPE, cs, rw};
   endfunction

   eep_state_t state_q, state_d;
   eep_op_t op_q;
   logic [CS_W-1:0] chip_q;
   logic [ADDR_W-1:0] addr_q;
   logic [LEN_W-1:0] remain_q;
   logic [1:0] phase_q;
   logic [3:0] bitCnt_q;
   logic [DATA_W-1:0] txSh_q, rxSh_q, rdData_q;
   logic ackSeen_q, haveByte_q, rdValid_q, done_q, nack_q;
   logic [QTR_W-1:0] divCnt_q;
   logic sdaMeta_q, sdaSync_q;
   logic scl_q, sdaLow_q, sclD, sdaLowD;
   logic fifoValid, fifoPop;
   logic [DATA_W-1:0] fifoData;
   logic tick, stall, step, endUnit, recovFree, accept;

   eep_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) eep_fifo_inst (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .inValid(wrValid),
      .inReady(wrReady),
      .inData(wrData),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoData)
   );

   // ***************************************************************
   // sampling, divider and sequencing strobes
   // ***************************************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sdaMeta_q <= 1'b1;
         sdaSync_q <= 1'b1;
      end else begin
         sdaMeta_q <= sdaIn;
         sdaSync_q <= sdaMeta_q;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         divCnt_q <= QTR_ZERO;
      end else if (state_q == ST_IDLE || tick) begin
         divCnt_q <= QTR_ZERO;
      end else begin
         divCnt_q <= divCnt_q + 1'b1;
      end
   end

   assign tick = (divCnt_q == QTR_LAST);
   assign accept = cmdValid && cmdReady;
   // hold clock low until a data byte is available
   assign stall = (state_q == ST_DATA) && (phase_q == PH_SET) && (bitCnt_q == BIT_FIRST) && !haveByte_q;
   assign fifoPop = stall && fifoValid;
   assign step = tick && !stall;
   assign endUnit = step && (phase_q == PH_FALL) && (!isBitSt(state_q) || bitCnt_q == BIT_ACK);
   assign recovFree = (state_q == ST_RECOV) && step && (phase_q == PH_SAMPLE) && sdaSync_q;

   // ***************************************************************
   // command sequence
   // ***************************************************************
   always_comb begin
      state_d = state_q;
      if (state_q == ST_IDLE) begin
         if (cmdValid) begin
            state_d = (cmdOp == OP_RECOVER) ? ST_RECOV : ST_START;
         end
      end else if (recovFree) begin
         state_d = ST_START;
      end else if (endUnit) begin
         unique case (state_q)
            ST_START: state_d = (op_q == OP_RECOVER) ? ST_STOP : ST_ADDR;
            ST_ADDR: begin
               if (!ackSeen_q || op_q == OP_POLL) begin
                  state_d = ST_STOP;
               end else if (op_q == OP_READ_CUR) begin
                  state_d = ST_RDATA;
               end else begin
                  state_d = ST_HI;
               end
            end
            ST_HI: state_d = ackSeen_q ? ST_LO : ST_STOP;
            ST_LO: begin
               if (!ackSeen_q) begin
                  state_d = ST_STOP;
               end else begin
                  state_d = (op_q == OP_WRITE) ? ST_DATA : ST_RSTART;
               end
            end
            ST_DATA: state_d = (!ackSeen_q || remain_q == LEN_ONE) ? ST_STOP : ST_DATA;
            ST_RSTART: state_d = ST_RADDR;
            ST_RADDR: state_d = ackSeen_q ? ST_RDATA : ST_STOP;
            ST_RDATA: state_d = (remain_q == LEN_ONE) ? ST_STOP : ST_RDATA;
            ST_STOP: state_d = ST_IDLE;
            ST_RECOV: state_d = ST_START;
            default: state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         phase_q <= PH_SET;
         bitCnt_q <= BIT_FIRST;
      end else begin
         state_q <= state_d;
         if (accept || recovFree || endUnit) begin
            phase_q <= PH_SET;
            bitCnt_q <= BIT_FIRST;
         end else if (step) begin
            phase_q <= phase_q + 1'b1;
            if (phase_q == PH_FALL && isBitSt(state_q)) begin
               bitCnt_q <= bitCnt_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         op_q <= OP_WRITE;
         chip_q <= '0;
         addr_q <= '0;
         remain_q <= LEN_ONE;
      end else if (accept) begin
         op_q <= cmdOp;
         chip_q <= cmdChip;
         addr_q <= cmdAddr;
         remain_q <= (cmdLen == LEN_ZERO) ? LEN_ONE : cmdLen;
      end else if (endUnit && (state_q == ST_DATA || state_q == ST_RDATA)) begin
         remain_q <= remain_q - 1'b1;
      end
   end

   // ***************************************************************
   // shift registers and acknowledge
   // ***************************************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         txSh_q <= '0;
         haveByte_q <= 1'b0;
      end else if (fifoPop) begin
         txSh_q <= fifoData;
         haveByte_q <= 1'b1;
      end else if (endUnit) begin
         haveByte_q <= 1'b0;
         unique case (state_d)
            ST_ADDR: txSh_q <= devByte(chip_q, (op_q == OP_READ_CUR) ? RW_READ : RW_WRITE);
            ST_HI: txSh_q <= {ADDR_HI_PAD, addr_q[ADDR_W-1:DATA_W]};
            ST_LO: txSh_q <= addr_q[DATA_W-1:0];
            ST_RADDR: txSh_q <= devByte(chip_q, RW_READ);
            default: txSh_q <= txSh_q;
         endcase
      end else if (step && phase_q == PH_FALL && isTx(state_q)) begin
         txSh_q <= {txSh_q[DATA_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rxSh_q <= '0;
         ackSeen_q <= 1'b0;
      end else if (step && phase_q == PH_SAMPLE) begin
         if (state_q == ST_RDATA && bitCnt_q != BIT_ACK) begin
            rxSh_q <= {rxSh_q[DATA_W-2:0], sdaSync_q};
         end
         if (isTx(state_q) && bitCnt_q == BIT_ACK) begin
            ackSeen_q <= !sdaSync_q;
         end
      end
   end

   // ***************************************************************
   // user-side results
   // ***************************************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdData_q <= '0;
         rdValid_q <= 1'b0;
         done_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         rdValid_q <= endUnit && (state_q == ST_RDATA);
         done_q <= endUnit && (state_q == ST_STOP);
         if (endUnit && state_q == ST_RDATA) begin
            rdData_q <= rxSh_q;
         end
         if (accept) begin
            nack_q <= 1'b0;
         end else if (endUnit && isTx(state_q) && !ackSeen_q) begin
            nack_q <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // bus line levels
   // ***************************************************************
   always_comb begin
      sclD = 1'b1;
      sdaLowD = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            sclD = 1'b1;
            sdaLowD = 1'b0;
         end
         ST_START, ST_RSTART: begin
            sclD = (phase_q == PH_RISE) || (phase_q == PH_SAMPLE);
            sdaLowD = (phase_q == PH_SAMPLE) || (phase_q == PH_FALL);
         end
         ST_STOP: begin
            sclD = (phase_q != PH_SET);
            sdaLowD = (phase_q == PH_SET) || (phase_q == PH_RISE);
         end
         ST_RDATA: begin
            sclD = (phase_q == PH_RISE) || (phase_q == PH_SAMPLE);
            sdaLowD = (bitCnt_q == BIT_ACK) && (remain_q != LEN_ONE);
         end
         ST_RECOV: begin
            sclD = (phase_q == PH_RISE) || (phase_q == PH_SAMPLE);
            sdaLowD = 1'b0;
         end
         ST_ADDR, ST_HI, ST_LO, ST_DATA, ST_RADDR: begin
            sclD = (phase_q == PH_RISE) || (phase_q == PH_SAMPLE);
            sdaLowD = (bitCnt_q != BIT_ACK) && !txSh_q[DATA_W-1];
         end
         default: begin
            sclD = 1'b1;
            sdaLowD = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         scl_q <= 1'b1;
         sdaLow_q <= 1'b0;
      end else begin
         scl_q <= sclD;
         sdaLow_q <= sdaLowD;
      end
   end

   assign scl = scl_q;
   assign sdaOut = 1'b0;
   assign sdaOeN = !sdaLow_q;
   assign cmdReady = (state_q == ST_IDLE);
   assign busy = (state_q != ST_IDLE);
   assign rdValid = rdValid_q;
   assign rdData = rdData_q;
   assign done = done_q;
   assign nackSeen = nack_q;

   // ***************************************************************
   // checks
   // ***************************************************************
   a_start_shape: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (state_q == ST_START && phase_q == PH_SAMPLE && tick) |-> (scl_q && sdaLow_q) ##2 (!scl_q && sdaLow_q))
      else $error("start condition malformed");
   a_stop_shape: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (state_q == ST_STOP && phase_q == PH_FALL && tick) |-> (scl_q && !sdaLow_q) ##2 (cmdReady && scl_q))
      else $error("stop condition malformed");
   a_sda_stable: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (scl_q && $past(scl_q) && isBitSt(state_q) && isBitSt($past(state_q))) |-> $stable(sdaLow_q))
      else $error("data moved while clock high");
   a_bit_count: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (step && phase_q == PH_FALL && isBitSt(state_q) && bitCnt_q != BIT_ACK && !recovFree)
      |=> (bitCnt_q == $past(bitCnt_q) + 4'h1) && !scl_q)
      else $error("bit count did not advance once per clock");
   a_ack_release: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (isTx(state_q) && bitCnt_q == BIT_ACK && phase_q == PH_SAMPLE && tick) |-> !sdaLow_q)
      else $error("master drove data in device acknowledge slot");
   a_read_ack: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (state_q == ST_RDATA && bitCnt_q == BIT_ACK && phase_q == PH_SAMPLE && tick)
      |-> (sdaLow_q == (remain_q != LEN_ONE)))
      else $error("read acknowledge wrong for byte position");
   a_addr_rw: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      ((state_q == ST_ADDR || state_q == ST_RADDR) && bitCnt_q == BIT_FIRST && phase_q == PH_SET)
      |-> (txSh_q[DATA_W-1:DATA_W-4] == DEV_TYPE)
          && (txSh_q[0] == (state_q == ST_RADDR || op_q == OP_READ_CUR)))
      else $error("address byte type or direction wrong");
   a_hi_byte: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (state_q == ST_HI && bitCnt_q == BIT_FIRST && phase_q == PH_SET)
      |-> (txSh_q == {ADDR_HI_PAD, addr_q[ADDR_W-1:DATA_W]}))
      else $error("high address byte wrong");
   a_write_order: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (state_q == ST_LO && endUnit && ackSeen_q && op_q == OP_WRITE) |=> (state_q == ST_DATA))
      else $error("data byte did not follow byte address");
   a_poll_stop: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (state_q == ST_ADDR && endUnit && op_q == OP_POLL) |=> (state_q == ST_STOP) && (nack_q == !$past(ackSeen_q)))
      else $error("poll did not close with stop and result");
   a_rand_rstart: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (state_q == ST_LO && endUnit && ackSeen_q && op_q == OP_READ_RAND) |=> (state_q == ST_RSTART))
      else $error("random read missed repeated start");
   a_recov_exit: assert property (
      @(posedge clk_sys) disable iff (!arst_n)
      (state_q == ST_RECOV && step && phase_q == PH_SAMPLE && sdaSync_q) |=> (state_q == ST_START))
      else $error("recovery did not move to start on released data");
endmodule // eep_host_ctrl

// ==== verification/eep_dev_model.sv ====
// Purpose: behavioural serial EEPROM on the two-wire bus
// Assumes: scl from the host, data line with pull-up
// Notes:   programming time shortened by PROG_NS
`timescale 1ns/100ps
module eep_dev_model #(
   parameter int PROG_NS = 100000
) (
   input wire logic scl, // bus clock
   input wire logic sda, // resolved data line
   input wire logic [2:0] chipSel, // chip-select pins
   input wire logic wpHigh, // write protect
   output logic pull // pulls data line low
);
   logic [7:0] mem [0:4095];
   logic [7:0] pg [0:31];
   logic [31:0] vld;
   logic [11:0] ptr;
   logic [7:0] sh, tx;
   logic act, rd, mAck, progBusy;
   int cnt, nb, nw;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      {pull, act, rd, progBusy, ptr} = '0;
   end
   always @(negedge sda) if (scl) begin
      {act, cnt, nb, nw, vld, pull, rd} = {1'b1, 96'h0, 32'h0, 2'h0};
   end
   always @(posedge sda) if (scl) begin
      if (act && !rd && nw > 0 && !wpHigh) begin
         for (int i = 0; i < 32; i++) if (vld[i]) mem[{ptr[11:5], i[4:0]}] = pg[i];
         progBusy = 1;
      end
      act = 0;
   end
   always @(posedge progBusy) #(PROG_NS) progBusy = 0;
   always @(posedge scl) if (act) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else mAck = !sda;
      cnt++;
   end
   always @(negedge scl) if (act) begin
      pull = 0;
      if (cnt == 8 && !(rd && nb > 0)) begin
         pull = 1;
         if (nb == 0) begin
            rd = sh[0];
            if (sh[7:4] != 4'hA || sh[3:1] != chipSel || progBusy) begin
               act = 0;
               pull = 0;
            end
         end else if (nb == 1) ptr[11:8] = sh[3:0];
         else if (nb == 2) ptr[7:0] = sh;
         else begin
            pg[ptr[4:0]] = sh;
            vld[ptr[4:0]] = 1;
            ptr[4:0] = ptr[4:0] + 5'h1;
            nw++;
         end
      end else if (cnt == 9) begin
         cnt = 0;
         nb++;
         if (rd && nb > 1 && !mAck) act = 0;
         else if (rd) begin
            tx = mem[ptr];
            ptr = ptr + 12'h1;
            pull = !tx[7];
         end
      end else if (rd && nb > 0 && cnt < 8) pull = !tx[7 - cnt];
   end
endmodule // eep_dev_model

// ==== verification/eep_host_ctrl_bench.sv ====
// Purpose: self-checking bench for the EEPROM host controller
// Assumes: device model with a short programming time
// Notes:   random data from a fixed seed
`timescale 1ns/100ps
module eep_host_ctrl_bench;
   import eep_pkg::*;
   logic clk_sys = 0, arst_n = 0, cmdValid = 0, wrValid = 0, wp = 0;
   eep_op_t cmdOp = OP_POLL;
   logic [CS_W-1:0] cmdChip = '0, cs;
   logic [ADDR_W-1:0] cmdAddr = '0, a;
   logic [LEN_W-1:0] cmdLen = '0;
   logic [DATA_W-1:0] wrData = '0, rdData, mir [0:4095], got [$], wq [$];
   logic cmdReady, wrReady, rdValid, busy, done, nackSeen, scl, sdaOut, sdaOeN, pull;
   int n_errors = 0, n_compared = 0;
   wire sda = !((sdaOeN === 1'b0 && sdaOut === 1'b0) || pull === 1'b1);
   always #10 clk_sys = ~clk_sys;
   eep_host_ctrl eep_host_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdChip(cmdChip), .cmdAddr(cmdAddr), .cmdLen(cmdLen),
      .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .rdValid(rdValid), .rdData(rdData),
      .busy(busy), .done(done), .nackSeen(nackSeen), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN));
   eep_dev_model #(.PROG_NS(40000)) eep_dev_model_inst (.scl(scl), .sda(sda), .chipSel(cs), .wpHigh(wp),
      .pull(pull));
   task automatic oops(input string m);
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic chkB(input logic [7:0] g, e);
      n_compared++;
      if (g !== e) oops($sformatf("byte %h expected %h", g, e));
   endtask
   task automatic chkF(input logic g, e);
      n_compared++;
      if (g !== e) oops("flag mismatch");
   endtask
   task automatic end_sim;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [11:0] pgAt(input logic [11:0] b, input int i);
      return {b[11:5], b[4:0] + i[4:0]};
   endfunction
   task automatic cmd(input eep_op_t op, input logic [2:0] ch, input logic [11:0] ad, input logic [5:0] ln);
      int n;
      @(negedge clk_sys);
      {cmdOp, cmdChip, cmdAddr, cmdLen, cmdValid} = {op, ch, ad, ln, 1'b1};
      @(negedge clk_sys);
      cmdValid = 0;
      chkF(busy && !cmdReady, 1'b1);
      got.delete();
      for (n = 0; n < 60000 && done !== 1'b1; n++) begin
         if (rdValid === 1'b1) got.push_back(rdData);
         @(negedge clk_sys);
      end
      if (n == 60000) begin
         oops("command hung");
         end_sim;
      end
      chkF(busy || !cmdReady, 1'b0);
   endtask
   // keeps the write FIFO topped up while the command runs
   task automatic feed(input int k);
      int i, t;
      i = 0;
      for (t = 0; i < k && t < 60000; t++) begin
         if (wrReady === 1'b1) begin
            wrData = 8'($urandom);
            wrValid = 1;
            wq.push_back(wrData);
            i++;
         end else begin
            wrValid = 0;
         end
         @(negedge clk_sys);
      end
      wrValid = 0;
   endtask
   task automatic wr(input logic [11:0] ad, input int k);
      wq.delete();
      fork
         feed(k);
         cmd(OP_WRITE, cs, ad, 6'(k));
      join
      chkB(8'(wq.size()), 8'(k));
      chkF(nackSeen, 1'b0);
      foreach (wq[i]) if (!wp) mir[pgAt(ad, i)] = wq[i];
   endtask
   task automatic rd(input eep_op_t op, input logic [11:0] ad, input int k);
      cmd(op, cs, ad, 6'(k));
      chkB(8'(got.size()), 8'(k));
      foreach (got[i]) chkB(got[i], mir[12'(ad + i)]);
   endtask
   task automatic pollUntil(input logic first);
      int t;
      cmd(OP_POLL, cs, 12'h0, 6'h1);
      chkF(nackSeen, first);
      for (t = 0; t < 30 && nackSeen !== 1'b0; t++) cmd(OP_POLL, cs, 12'h0, 6'h1);
      if (t == 30) begin
         oops("poll hung");
         end_sim;
      end
   endtask
   initial begin
      void'($urandom(32'hE246057E));
      foreach (mir[i]) mir[i] = 8'h00;
      cs = 3'($urandom);
      a = {7'($urandom), 5'h14};
      repeat (20) @(negedge clk_sys);
      arst_n = 1;
      @(negedge clk_sys);
      wr(a, 33);
      pollUntil(1'b1);
      cmd(OP_POLL, cs ^ 3'h5, 12'h0, 6'h1);
      chkF(nackSeen, 1'b1);
      rd(OP_READ_RAND, a, 3);
      rd(OP_READ_RAND, {a[11:5], 5'h0}, 4);
      rd(OP_READ_CUR, {a[11:5], 5'h4}, 1);
      wr(12'hFFF, 1);
      pollUntil(1'b1);
      rd(OP_READ_RAND, 12'hFFF, 2);
      wp = 1;
      wr(12'h100, 2);
      pollUntil(1'b0);
      wp = 0;
      cmd(OP_RECOVER, cs, 12'h0, 6'h1);
      rd(OP_READ_RAND, 12'h100, 2);
      rd(OP_READ_CUR, 12'h102, 1);
      end_sim;
   end
endmodule // eep_host_ctrl_bench
